// ### csspx_pkg.sv
package csspx_pkg;

  // =====================================================
  // opcodes
  localparam logic [7:0] OP_SCF = 8'hdf;
  localparam logic [7:0] OP_SRA_R = 8'hd0;
  localparam logic [7:0] OP_SRA_IR = 8'hd1;
  localparam logic [7:0] OP_SRP = 8'h31;
  localparam logic [7:0] OP_STOP = 8'h7f;
  localparam logic [7:0] OP_SUB_RR = 8'h22;
  localparam logic [7:0] OP_SUB_RIR = 8'h23;
  localparam logic [7:0] OP_SUB_DD = 8'h24;
  localparam logic [7:0] OP_SUB_DIR = 8'h25;
  localparam logic [7:0] OP_SUB_DIM = 8'h26;

  // =====================================================
  // execution lengths in clock cycles
  localparam logic [2:0] CYC_SHORT = 3'h4;
  localparam logic [2:0] CYC_LONG = 3'h6;

  // =====================================================
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_FLAGS = 8'hd5;
  localparam logic [7:0] IDX_PTR_FIRST = 8'hd6;
  localparam logic [7:0] IDX_PTR_SECOND = 8'hd7;
  localparam logic [7:0] IDX_STATUS = 8'hd8;
  localparam int STAT_STOP_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;

  // =====================================================
  // reset values
  localparam logic [7:0] RST_PTR_FIRST = 8'h00;
  localparam logic [7:0] RST_PTR_SECOND = 8'h08;
  localparam logic [7:0] RST_FLAGS = 8'h00;

  // =====================================================
  // pointer select patterns in immediate bits 1:0
  localparam logic [1:0] SEL_BOTH = 2'h0;
  localparam logic [1:0] SEL_SECOND = 2'h1;
  localparam logic [1:0] SEL_FIRST = 2'h2;

  // =====================================================
  // types
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] b1;
    logic [7:0] b2;
  } csspx_instr_t;

  typedef struct packed {
    logic c;
    logic z;
    logic s;
    logic v;
    logic d;
    logic h;
    logic [1:0] rsv;
  } csspx_flags_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_STOP = 3'b100
  } csspx_state_t;

endpackage

// ### csspx_alu.sv
`timescale 1ns/1ns
module csspx_alu (
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic sel_sra,
  input wire csspx_pkg::csspx_flags_t flags_in,
  output logic [7:0] res,
  output csspx_pkg::csspx_flags_t flags_out
);

  logic [8:0] diff;
  logic [4:0] low_sum;

  // =====================================================
  // subtract and arithmetic shift
  always_comb begin
    diff = {1'b0, a} - {1'b0, b};
    // low nibble done as add of the complement to expose its carry
    low_sum = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
    flags_out = flags_in;
    if (sel_sra) begin
      res = {a[7], a[7:1]};
      flags_out.c = a[0];
      flags_out.z = (res == 8'h00);
      flags_out.s = res[7];
      flags_out.v = 1'b0;
    end else begin
      res = diff[7:0];
      flags_out.c = diff[8];
      flags_out.z = (res == 8'h00);
      flags_out.s = res[7];
      flags_out.v = (a[7] != b[7]) && (res[7] == b[7]);
      flags_out.d = 1'b1;
      flags_out.h = ~low_sum[4];
    end
  end

endmodule

// ### csspx_ptr.sv
`timescale 1ns/1ns
module csspx_ptr (
  input wire logic [7:0] imm,
  input wire logic [7:0] first_in,
  input wire logic [7:0] second_in,
  output logic [7:0] first_out,
  output logic [7:0] second_out
);

  // =====================================================
  // pointer load, pattern 11 leaves both alone
  always_comb begin
    first_out = first_in;
    second_out = second_in;
    case (imm[1:0])
      csspx_pkg::SEL_FIRST: begin
        first_out = {imm[7:3], first_in[2:0]};
      end
      csspx_pkg::SEL_SECOND: begin
        second_out = {imm[7:3], second_in[2:0]};
      end
      csspx_pkg::SEL_BOTH: begin
        first_out = {imm[7:4], 1'b0, first_in[2:0]};
        second_out = {imm[7:4], 1'b1, second_in[2:0]};
      end
      default: begin
        first_out = first_in;
      end
    endcase
  end

endmodule

// ### csspx_core.sv
// Notes on behaviour
// - set carry forces carry, 1 byte, 4 cycles
// - arithmetic shift right keeps and copies bit 7
// - shift sets Z, S; clears V; keeps D, H
// - shift is 2 bytes, 4 cycles, D0/D1
// - pattern 10/01 loads one pointer bits 3-7
// - pattern 00 loads both; bit3 0 and 1
// - set pointer opcode 31, 4 cycles, D6/D7
// - stop halts clocks, enters stop, no flags; core does not gate hclk, only freezes its state
// - stop mode retains all register contents
// - reset or external interrupt ends stop mode
// - subtract dst minus src, opcodes 22-26
// - subtract sets C on borrow, Z, S
// - subtract overflow on opposite signs rule
// - subtract forces D; H marks nibble borrow
// - subtract takes 4 or 6 cycles by form
`timescale 1ns/1ns
module csspx_core #(
  parameter int DEPTH = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic instr_valid,
  input wire csspx_pkg::csspx_instr_t instr,
  output logic instr_ready,
  output logic instr_done,
  input wire logic ext_irq,
  output logic stop_mode
);

  localparam int AW = $clog2(DEPTH);

  // =====================================================
  // state
  csspx_pkg::csspx_state_t state_r, state_nxt;
  csspx_pkg::csspx_instr_t cur_r, cur_nxt;
  csspx_pkg::csspx_flags_t flags_r, flags_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [7:0] ptr0_r, ptr0_nxt;
  logic [7:0] ptr1_r, ptr1_nxt;
  logic [7:0] regs_r [DEPTH];
  logic [7:0] regs_nxt [DEPTH];
  logic dp_wr_r, dp_wr_nxt;
  logic [7:0] dp_idx_r, dp_idx_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  logic done, accept, bus_take, mapped;
  logic [7:0] dst_a, dst_v, src_v, alu_res, p0_out, p1_out;
  logic [7:0] wr_a, wr_d;
  logic wr_en, sel_sra, is_alu;
  csspx_pkg::csspx_flags_t alu_flags;

  // =====================================================
  // decode helpers
  function automatic logic [2:0] op_cycles(input logic [7:0] op);
    case (op)
      csspx_pkg::OP_SUB_RIR, csspx_pkg::OP_SUB_DD,
      csspx_pkg::OP_SUB_DIR, csspx_pkg::OP_SUB_DIM: op_cycles = csspx_pkg::CYC_LONG;
      default: op_cycles = csspx_pkg::CYC_SHORT;
    endcase
  endfunction

  function automatic logic [7:0] wreg(input logic [3:0] n, input logic [7:0] p0,
                                      input logic [7:0] p1);
    wreg = n[3] ? {p1[7:3], n[2:0]} : {p0[7:3], n[2:0]};
  endfunction

  // reads the register space as the core sees it
  function automatic logic [7:0] rd(input logic [7:0] a);
    if (int'(a) < DEPTH) begin
      rd = regs_r[a[AW-1:0]];
    end else begin
      case (a)
        csspx_pkg::IDX_FLAGS: rd = flags_r;
        csspx_pkg::IDX_PTR_FIRST: rd = ptr0_r;
        csspx_pkg::IDX_PTR_SECOND: rd = ptr1_r;
        default: rd = 8'h00;
      endcase
    end
  endfunction

  // =====================================================
  // operand fetch
  always_comb begin
    dst_a = 8'h00;
    src_v = 8'h00;
    sel_sra = 1'b0;
    is_alu = 1'b1;
    case (cur_r.opcode)
      csspx_pkg::OP_SUB_RR: begin
        dst_a = wreg(cur_r.b1[7:4], ptr0_r, ptr1_r);
        src_v = rd(wreg(cur_r.b1[3:0], ptr0_r, ptr1_r));
      end
      csspx_pkg::OP_SUB_RIR: begin
        dst_a = wreg(cur_r.b1[7:4], ptr0_r, ptr1_r);
        src_v = rd(rd(wreg(cur_r.b1[3:0], ptr0_r, ptr1_r)));
      end
      csspx_pkg::OP_SUB_DD: begin
        dst_a = cur_r.b2;
        src_v = rd(cur_r.b1);
      end
      csspx_pkg::OP_SUB_DIR: begin
        dst_a = cur_r.b2;
        src_v = rd(rd(cur_r.b1));
      end
      csspx_pkg::OP_SUB_DIM: begin
        dst_a = cur_r.b1;
        src_v = cur_r.b2;
      end
      csspx_pkg::OP_SRA_R: begin
        dst_a = cur_r.b1;
        sel_sra = 1'b1;
      end
      csspx_pkg::OP_SRA_IR: begin
        dst_a = rd(cur_r.b1);
        sel_sra = 1'b1;
      end
      default: begin
        is_alu = 1'b0;
      end
    endcase
    dst_v = rd(dst_a);
  end

  csspx_alu u_alu (
    .a(dst_v),
    .b(src_v),
    .sel_sra(sel_sra),
    .flags_in(flags_r),
    .res(alu_res),
    .flags_out(alu_flags)
  );

  csspx_ptr u_ptr (
    .imm(cur_r.b1),
    .first_in(ptr0_r),
    .second_in(ptr1_r),
    .first_out(p0_out),
    .second_out(p1_out)
  );

  // =====================================================
  // sequencing
  assign done = (state_r == csspx_pkg::ST_EXEC) && (cnt_r == 3'h0);
  assign instr_ready = (state_r == csspx_pkg::ST_IDLE) ||
                       (done && cur_r.opcode != csspx_pkg::OP_STOP);
  assign accept = instr_valid && instr_ready;
  assign instr_done = done;
  assign stop_mode = (state_r == csspx_pkg::ST_STOP);

  // one write port: instruction result beats a bus write
  always_comb begin
    wr_en = dp_wr_r && !stop_mode;
    wr_a = dp_idx_r;
    wr_d = hwdata[7:0];
    if (done && is_alu) begin
      wr_en = 1'b1;
      wr_a = dst_a;
      wr_d = alu_res;
    end
  end

  always_comb begin
    state_nxt = state_r;
    cur_nxt = cur_r;
    cnt_nxt = cnt_r;
    flags_nxt = flags_r;
    ptr0_nxt = ptr0_r;
    ptr1_nxt = ptr1_r;
    regs_nxt = regs_r;
    if (wr_en) begin
      if (int'(wr_a) < DEPTH) begin
        regs_nxt[wr_a[AW-1:0]] = wr_d;
      end else begin
        case (wr_a)
          csspx_pkg::IDX_FLAGS: flags_nxt = {wr_d[7:2], 2'h0};
          csspx_pkg::IDX_PTR_FIRST: ptr0_nxt = wr_d;
          csspx_pkg::IDX_PTR_SECOND: ptr1_nxt = wr_d;
          default: ;
        endcase
      end
    end
    if (done) begin
      state_nxt = csspx_pkg::ST_IDLE;
      if (is_alu) begin
        flags_nxt = alu_flags;
      end
      case (cur_r.opcode)
        csspx_pkg::OP_SCF: flags_nxt.c = 1'b1;
        csspx_pkg::OP_SRP: begin
          ptr0_nxt = p0_out;
          ptr1_nxt = p1_out;
        end
        csspx_pkg::OP_STOP: state_nxt = csspx_pkg::ST_STOP;
        default: ;
      endcase
    end else if (state_r == csspx_pkg::ST_EXEC) begin
      cnt_nxt = cnt_r - 3'h1;
    end
    if (accept) begin
      state_nxt = csspx_pkg::ST_EXEC;
      cur_nxt = instr;
      cnt_nxt = op_cycles(instr.opcode) - 3'h1;
    end
    // reset wakes through hresetn itself
    if (stop_mode && ext_irq) begin
      state_nxt = csspx_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= csspx_pkg::ST_IDLE;
      cur_r <= '0;
      cnt_r <= 3'h0;
      flags_r <= csspx_pkg::RST_FLAGS;
      ptr0_r <= csspx_pkg::RST_PTR_FIRST;
      ptr1_r <= csspx_pkg::RST_PTR_SECOND;
      for (int i = 0; i < DEPTH; i++) begin
        regs_r[i] <= 8'h00;
      end
    end else begin
      state_r <= state_nxt;
      cur_r <= cur_nxt;
      cnt_r <= cnt_nxt;
      flags_r <= flags_nxt;
      ptr0_r <= ptr0_nxt;
      ptr1_r <= ptr1_nxt;
      regs_r <= regs_nxt;
    end
  end

  // =====================================================
  // ahb-lite slave, zero wait states
  assign bus_take = hsel && htrans[1] && hready;
  assign mapped = (haddr[31:10] == 22'h0);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_r;

  always_comb begin
    dp_wr_nxt = bus_take && hwrite && mapped;
    dp_idx_nxt = haddr[9:2];
    rdata_nxt = rdata_r;
    if (bus_take && !hwrite) begin
      rdata_nxt = 32'h0;
      if (mapped && haddr[9:2] == csspx_pkg::IDX_STATUS) begin
        rdata_nxt[csspx_pkg::STAT_STOP_BIT] = stop_mode;
        rdata_nxt[csspx_pkg::STAT_BUSY_BIT] = (state_r == csspx_pkg::ST_EXEC);
      end else if (mapped) begin
        rdata_nxt[7:0] = rd(haddr[9:2]);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_r <= 1'b0;
      dp_idx_r <= 8'h00;
      rdata_r <= 32'h0;
    end else begin
      dp_wr_r <= dp_wr_nxt;
      dp_idx_r <= dp_idx_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // =====================================================
  // checks
  chk_scf_carry: assert property (@(posedge hclk) disable iff (!hresetn)
    (done && cur_r.opcode == csspx_pkg::OP_SCF && !wr_en) |=>
    (flags_r.c && flags_r[6:2] == $past(flags_r[6:2])))
    else $error("set carry did not force carry alone");

  chk_sra_bits: assert property (@(posedge hclk) disable iff (!hresetn)
    (done && sel_sra) |-> (alu_res[7:6] == {2{dst_v[7]}} && alu_flags.c == dst_v[0]
    && alu_res[5:0] == dst_v[6:1]))
    else $error("arithmetic shift bits wrong");

  chk_sra_flags: assert property (@(posedge hclk) disable iff (!hresetn)
    (done && sel_sra && wr_a != csspx_pkg::IDX_FLAGS) |=>
    (!flags_r.v && flags_r.d == $past(flags_r.d) && flags_r.h == $past(flags_r.h)
    && flags_r.z == ($past(alu_res) == 8'h00)))
    else $error("arithmetic shift flags wrong");

  chk_short_len: assert property (@(posedge hclk) disable iff (!hresetn)
    (accept && op_cycles(instr.opcode) == csspx_pkg::CYC_SHORT && !ext_irq) |=>
    (!done)[*3] ##1 done)
    else $error("short instruction length wrong");

  chk_long_len: assert property (@(posedge hclk) disable iff (!hresetn)
    (accept && op_cycles(instr.opcode) == csspx_pkg::CYC_LONG && !ext_irq) |=>
    (!done)[*5] ##1 done)
    else $error("long subtract length wrong");

  chk_ptr_single: assert property (@(posedge hclk) disable iff (!hresetn)
    (done && cur_r.opcode == csspx_pkg::OP_SRP && cur_r.b1[1:0] == csspx_pkg::SEL_FIRST
    && !dp_wr_r) |=> (ptr0_r[7:3] == $past(cur_r.b1[7:3]) && $stable(ptr1_r)))
    else $error("single pointer load wrong");

  chk_ptr_both: assert property (@(posedge hclk) disable iff (!hresetn)
    (done && cur_r.opcode == csspx_pkg::OP_SRP && cur_r.b1[1:0] == csspx_pkg::SEL_BOTH
    && !dp_wr_r) |=> (!ptr0_r[3] && ptr1_r[3] && ptr0_r[7:4] == $past(cur_r.b1[7:4])
    && ptr1_r[7:4] == $past(cur_r.b1[7:4])))
    else $error("dual pointer load wrong");

  chk_stop_enter: assert property (@(posedge hclk) disable iff (!hresetn)
    (done && cur_r.opcode == csspx_pkg::OP_STOP && !ext_irq && !dp_wr_r) |=>
    (stop_mode && $stable(flags_r) && !instr_ready))
    else $error("stop did not enter stop mode");

  chk_stop_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (stop_mode && !ext_irq) |=> ($stable(flags_r) && $stable(ptr0_r) && $stable(ptr1_r)
    && stop_mode))
    else $error("state changed in stop mode");

  chk_stop_wake: assert property (@(posedge hclk) disable iff (!hresetn)
    (stop_mode && ext_irq) |=> (!stop_mode && instr_ready))
    else $error("interrupt did not end stop mode");

  chk_sub_flags: assert property (@(posedge hclk) disable iff (!hresetn)
    (done && is_alu && !sel_sra) |-> (alu_flags.c == (src_v > dst_v) && alu_flags.d
    && alu_flags.h == (src_v[3:0] > dst_v[3:0]) && alu_res == dst_v - src_v))
    else $error("subtract result or flags wrong");

endmodule

// ### tb_csspx_core.sv
`timescale 1ns/1ns
module tb_csspx_core;
  // =====================================================
  // stimulus and observation
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic instr_valid = 1'b0;
  csspx_pkg::csspx_instr_t instr = 24'h0;
  logic instr_ready;
  logic instr_done;
  logic ext_irq = 1'b0;
  logic stop_mode;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  int n;
  logic [31:0] rd;
  // left undecoded by this block, so it runs as a plain four-cycle no-op
  localparam logic [7:0] no_operation_instr = 8'h00;

  initial begin
    forever #50 hclk = ~hclk;
  end

  // single slave, so its ready is the bus ready
  csspx_core #(.DEPTH(16)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .instr_valid(instr_valid),
    .instr(instr), .instr_ready(instr_ready), .instr_done(instr_done), .ext_irq(ext_irq),
    .stop_mode(stop_mode));

  // =====================================================
  // helpers
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // address phase held until ready, then data phase until ready again
  task automatic bus(input logic wr, input logic [31:0] addr, input logic [7:0] wd,
                     output logic [31:0] rdv);
    hsel <= 1'b1;
    haddr <= addr;
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= {24'h0, wd};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rdv = hrdata;
    check("bus response", 32'(hresp), 32'h0);
  endtask

  task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] dummy;
    bus(1'b1, {22'h0, idx, 2'h0}, d, dummy);
  endtask

  task automatic rreg(input logic [7:0] idx, output logic [31:0] v);
    bus(1'b0, {22'h0, idx, 2'h0}, 8'h00, v);
  endtask

  // returns the count of edges from take to the done cycle
  task automatic exec(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2,
                      output int cnt);
    int bad;
    bad = 0;
    instr_valid <= 1'b1;
    instr <= {op, b1, b2};
    @(posedge hclk);
    while (instr_ready !== 1'b1) @(posedge hclk);
    instr_valid <= 1'b0;
    cnt = 0;
    do begin
      @(posedge hclk);
      cnt++;
      if (instr_done !== 1'b1 && instr_ready !== 1'b0) bad++;
    end while (instr_done !== 1'b1 && cnt < 20);
    check("refused while busy", 32'(bad), 32'h0);
  endtask

  task automatic sra_case(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] tgt,
                          input logic [7:0] v);
    logic [31:0] f;
    logic [7:0] r;
    r = {v[7], v[7:1]};
    rreg(csspx_pkg::IDX_FLAGS, f);
    exec(op, b1, 8'h00, n);
    check("shift cycles", 32'(n), 32'h4);
    rreg(tgt, rd);
    check("shift result", rd, {24'h0, r});
    rreg(csspx_pkg::IDX_FLAGS, rd);
    check("shift flags", rd, {24'h0, v[0], r == 8'h0, r[7], 1'b0, f[3:2], 2'h0});
    rreg(b1, rd);
    if (op == csspx_pkg::OP_SRA_IR) check("shift pointer reg", rd, {24'h0, b1 + 8'h1});
  endtask

  task automatic sub_case(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2,
                          input logic [7:0] dv, input logic [7:0] sv, input int cyc);
    logic ind;
    logic [7:0] r;
    ind = (op == csspx_pkg::OP_SUB_RIR) || (op == csspx_pkg::OP_SUB_DIR);
    r = dv - sv;
    wreg(8'h01, dv);
    wreg(8'h02, ind ? 8'h03 : sv);
    wreg(8'h03, sv);
    wreg(csspx_pkg::IDX_FLAGS, 8'h00);
    exec(op, b1, b2, n);
    check("sub cycles", 32'(n), 32'(cyc));
    rreg(8'h01, rd);
    check("sub result", rd, {24'h0, r});
    rreg(8'h02, rd);
    check("sub pointer reg", rd, {24'h0, ind ? 8'h03 : sv});
    rreg(8'h03, rd);
    check("sub source", rd, {24'h0, sv});
    rreg(csspx_pkg::IDX_FLAGS, rd);
    check("sub flags", rd, {24'h0, sv > dv, r == 8'h0, r[7], (dv[7] ^ sv[7]) & (r[7] == sv[7]),
      1'b1, dv[3:0] < sv[3:0], 2'h0});
  endtask

  task automatic srp_case(input logic [7:0] imm, input logic [7:0] e1, input logic [7:0] e2);
    exec(csspx_pkg::OP_SRP, imm, 8'h00, n);
    check("pointer cycles", 32'(n), 32'h4);
    rreg(csspx_pkg::IDX_PTR_FIRST, rd);
    check("first pointer", rd, {24'h0, e1});
    rreg(csspx_pkg::IDX_PTR_SECOND, rd);
    check("second pointer", rd, {24'h0, e2});
  endtask

  // =====================================================
  // hang guard, well above the few hundred cycles needed
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      final_report();
    end
  end

  // =====================================================
  // main sequence
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rreg(csspx_pkg::IDX_PTR_FIRST, rd);
    check("first pointer reset", rd, 32'h0);
    rreg(csspx_pkg::IDX_PTR_SECOND, rd);
    check("second pointer reset", rd, 32'h8);
    bus(1'b0, 32'h0000_0400, 8'h00, rd);
    check("unmapped read", rd, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 2; i++) begin
      wreg(csspx_pkg::IDX_FLAGS, i == 0 ? 8'h7c : 8'hfc);
      exec(csspx_pkg::OP_SCF, 8'h00, 8'h00, n);
      check("carry set cycles", 32'(n), 32'h4);
      rreg(csspx_pkg::IDX_FLAGS, rd);
      check("carry set flags", rd, 32'hfc);
    end
    $display("test set carry done");
    wreg(8'h00, 8'h9a);
    wreg(8'h02, 8'h03);
    wreg(8'h03, 8'hbc);
    wreg(8'h04, 8'h01);
    wreg(csspx_pkg::IDX_FLAGS, 8'h9c);
    sra_case(csspx_pkg::OP_SRA_R, 8'h00, 8'h00, 8'h9a);
    sra_case(csspx_pkg::OP_SRA_IR, 8'h02, 8'h03, 8'hbc);
    sra_case(csspx_pkg::OP_SRA_R, 8'h04, 8'h04, 8'h01);
    $display("test shift done");
    sub_case(csspx_pkg::OP_SUB_RR, 8'h12, 8'h00, 8'h12, 8'h03, 4);
    sub_case(csspx_pkg::OP_SUB_RIR, 8'h12, 8'h00, 8'h12, 8'h0a, 6);
    sub_case(csspx_pkg::OP_SUB_DD, 8'h02, 8'h01, 8'h21, 8'h21, 6);
    sub_case(csspx_pkg::OP_SUB_DIR, 8'h02, 8'h01, 8'h80, 8'h01, 6);
    sub_case(csspx_pkg::OP_SUB_DIM, 8'h01, 8'h90, 8'h21, 8'h90, 6);
    $display("test subtract done");
    wreg(csspx_pkg::IDX_PTR_FIRST, 8'h00);
    wreg(csspx_pkg::IDX_PTR_SECOND, 8'h00);
    srp_case(8'h40, 8'h40, 8'h48);
    wreg(csspx_pkg::IDX_PTR_FIRST, 8'h07);
    srp_case(8'h52, 8'h57, 8'h48);
    srp_case(8'h69, 8'h57, 8'h68);
    srp_case(8'h0b, 8'h57, 8'h68);
    wreg(csspx_pkg::IDX_PTR_FIRST, 8'h00);
    wreg(csspx_pkg::IDX_PTR_SECOND, 8'h08);
    $display("test pointers done");
    wreg(8'h05, 8'h5a);
    wreg(csspx_pkg::IDX_FLAGS, 8'h34);
    exec(csspx_pkg::OP_STOP, 8'h00, 8'h00, n);
    check("stop cycles", 32'(n), 32'h4);
    @(posedge hclk);
    check("stop entered", 32'(stop_mode), 32'h1);
    check("no take in stop", 32'(instr_ready), 32'h0);
    rreg(csspx_pkg::IDX_FLAGS, rd);
    check("stop flags", rd, 32'h34);
    wreg(8'h05, 8'ha5);
    rreg(8'h05, rd);
    check("stop retains", rd, 32'h5a);
    rreg(csspx_pkg::IDX_STATUS, rd);
    check("status stop bit", 32'(rd[csspx_pkg::STAT_STOP_BIT]), 32'h1);
    ext_irq <= 1'b1;
    @(posedge hclk);
    ext_irq <= 1'b0;
    @(posedge hclk);
    check("wake by interrupt", 32'(stop_mode), 32'h0);
    rreg(8'h05, rd);
    check("kept after wake", rd, 32'h5a);
    for (int k = 0; k < 3; k++) begin
      exec(no_operation_instr, 8'h00, 8'h00, n);
      check("no-op cycles", 32'(n), 32'h4);
    end
    rreg(csspx_pkg::IDX_FLAGS, rd);
    check("flags after no-ops", rd, 32'h34);
    // off its reset value so that the reset wake below shows up
    wreg(csspx_pkg::IDX_PTR_SECOND, 8'h18);
    exec(csspx_pkg::OP_STOP, 8'h00, 8'h00, n);
    @(posedge hclk);
    check("stop again", 32'(stop_mode), 32'h1);
    hresetn <= 1'b0;
    repeat (4) @(posedge hclk);
    check("wake by reset", 32'(stop_mode), 32'h0);
    hresetn <= 1'b1;
    @(posedge hclk);
    rreg(csspx_pkg::IDX_PTR_SECOND, rd);
    check("pointer after reset", rd, 32'h8);
    $display("test stop done");
    final_report();
  end
endmodule
